// >>> logic/rbd_pkg.sv
package rbd_pkg;

  // Row and address geometry.
  localparam int unsigned ROWS        = 8;
  localparam int unsigned REGS        = 16;
  localparam int unsigned BND_W       = 12;
  localparam int unsigned MA_W        = 14;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] ROW0_BOUNDARY_LOW_IDX           = 8'h60;
  localparam logic [7:0] ROW0_BOUNDARY_HIGH_TYPE_MAP_IDX = 8'h61;
  localparam logic [7:0] ROW1_BOUNDARY_LOW_IDX           = 8'h62;
  localparam logic [7:0] ROW1_BOUNDARY_HIGH_TYPE_MAP_IDX = 8'h63;
  localparam logic [7:0] ROW2_BOUNDARY_LOW_IDX           = 8'h64;
  localparam logic [7:0] ROW2_BOUNDARY_HIGH_TYPE_MAP_IDX = 8'h65;
  localparam logic [7:0] ROW3_BOUNDARY_LOW_IDX           = 8'h66;
  localparam logic [7:0] ROW7_BOUNDARY_HIGH_TYPE_MAP_IDX = 8'h6F;

  // Field positions of the second register of a row.
  localparam int unsigned BND_HI_LSB  = 0;
  localparam int unsigned BND_HI_W    = 4;
  localparam int unsigned TYPE_LSB    = 4;
  localparam int unsigned MAP_LSB     = 6;

  // Reset values.
  localparam logic [7:0] ROW0_LOW_RST  = 8'h08;
  localparam logic [7:0] ROW0_HIGH_RST = 8'h40;
  localparam logic [7:0] ROWX_RST      = 8'h00;

  // Bank select positions on the memory address bus.
  localparam int unsigned BANK_LSB_64M = 11;
  localparam int unsigned BANK_LSB_X16 = 12;

  typedef enum logic [1:0] {
    TYPE_FPM   = 2'h0,
    TYPE_EDO   = 2'h1,
    TYPE_RSVD  = 2'h2,
    TYPE_SDRAM = 2'h3
  } rbd_type_e;

  typedef enum logic [1:0] {
    MAP_OFF = 2'h0,
    MAP_STD = 2'h1,
    MAP_64M = 2'h2,
    MAP_X16 = 2'h3
  } rbd_map_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } rbd_apb_e;

endpackage

// >>> logic/rbd_row_cmp.sv
`timescale 1ns/1ps
module rbd_row_cmp (
  // Access address in 1MB units
  input  wire logic [11:0] addr,
  // Row window
  input  wire logic [11:0] lo_bound,
  input  wire logic [11:0] hi_bound,
  input  wire logic        enabled,
  // Result
  output logic             hit
);

  // Cumulative bounds make each row the half-open span above its predecessor.
  assign hit = enabled && (addr >= lo_bound) && (addr < hi_bound);

endmodule

// >>> logic/rbd_bank_place.sv
`timescale 1ns/1ps
module rbd_bank_place (
  // Row setting
  input  wire logic [1:0]  mem_type,
  input  wire logic [1:0]  map_sel,
  // Bank of the access
  input  wire logic [1:0]  bank,
  // Memory address bank bits
  output logic      [13:0] ma
);

  always_comb
  begin
    ma = 14'h0000;
    if (mem_type == rbd_pkg::TYPE_SDRAM)
    begin
      if (map_sel == rbd_pkg::MAP_64M)
        ma[rbd_pkg::BANK_LSB_64M +: 2] = bank;
      else if (map_sel == rbd_pkg::MAP_X16)
        ma[rbd_pkg::BANK_LSB_X16 +: 2] = bank;
    end
  end

endmodule

// >>> logic/rbd_top.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module rbd_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Access request
  input  wire logic        acc_valid,
  input  wire logic [11:0] acc_addr,
  input  wire logic [1:0]  acc_bank,
  // Access answer and memory pins
  output logic      [7:0]  row_strobe_n,
  output logic      [13:0] memory_address_bus,
  output logic             acc_done,
  output logic             acc_miss,
  output logic      [2:0]  acc_row,
  output logic      [1:0]  acc_type,
  output logic      [1:0]  acc_map
);

  typedef struct packed {
    rbd_pkg::rbd_apb_e st;
    logic [15:0][7:0]  regs;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [7:0]        strobe_n;
    logic [13:0]       ma;
    logic              done;
    logic              miss;
    logic [2:0]        row;
    logic [1:0]        typ;
    logic [1:0]        map;
  } rbd_state_s;

  rbd_state_s s_r;
  rbd_state_s s_nxt;

  logic [7:0]  row_hit;
  logic [11:0] lo_bound [8];
  logic [11:0] hi_bound [8];
  logic [7:0]  row_en;
  logic [13:0] ma_of_row [8];

  // Returns a valid flag and the register number for a bus address.
  function automatic logic [4:0] reg_decode(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[1:0] != 2'h0)
      return 5'h00;
    else if (idx < {2'h0, rbd_pkg::ROW0_BOUNDARY_LOW_IDX})
      return 5'h00;
    else if (idx > {2'h0, rbd_pkg::ROW7_BOUNDARY_HIGH_TYPE_MAP_IDX})
      return 5'h00;
    else
      return {1'b1, idx[3:0]};
  endfunction

  // Boundary of a row in 1MB units: high nibble above low byte.
  function automatic logic [11:0] bound_of(input logic [15:0][7:0] r, input int x);
    return {r[2*x+1][rbd_pkg::BND_HI_LSB +: rbd_pkg::BND_HI_W], r[2*x]};
  endfunction

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_row
      logic [1:0] typ_g;
      logic [1:0] map_g;
      assign typ_g       = s_r.regs[2*g+1][rbd_pkg::TYPE_LSB +: 2];
      assign map_g       = s_r.regs[2*g+1][rbd_pkg::MAP_LSB +: 2];
      assign hi_bound[g] = bound_of(s_r.regs, g);
      if (g == 0)
      begin : g_first
        assign lo_bound[g] = 12'h000;
      end
      else
      begin : g_rest
        assign lo_bound[g] = bound_of(s_r.regs, g - 1);
      end
      // A reserved type is never strobed, whatever its map.
      assign row_en[g] = (typ_g == rbd_pkg::TYPE_SDRAM) ||
                         ((typ_g != rbd_pkg::TYPE_RSVD) && (map_g != rbd_pkg::MAP_OFF));
      rbd_row_cmp u_cmp (
        .addr     (acc_addr),
        .lo_bound (lo_bound[g]),
        .hi_bound (hi_bound[g]),
        .enabled  (row_en[g]),
        .hit      (row_hit[g])
      );
      rbd_bank_place u_bank (
        .mem_type (typ_g),
        .map_sel  (map_g),
        .bank     (acc_bank),
        .ma       (ma_of_row[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic [4:0] dec;
    logic       found;
    dec   = reg_decode(paddr);
    found = 1'b0;
    s_nxt = s_r;
    s_nxt.done     = 1'b0;
    s_nxt.miss     = 1'b0;
    s_nxt.strobe_n = 8'hFF;
    case (s_r.st)
      rbd_pkg::ST_IDLE:
      begin
        if (psel && !penable)
        begin
          s_nxt.st      = rbd_pkg::ST_RESP;
          s_nxt.pready  = 1'b1;
          s_nxt.pslverr = !dec[4];
          s_nxt.prdata  = dec[4] ? {24'h000000, s_r.regs[dec[3:0]]} : 32'h00000000;
        end
      end
      rbd_pkg::ST_RESP:
      begin
        if (psel && penable)
        begin
          if (pwrite && dec[4] && pstrb[0])
            s_nxt.regs[dec[3:0]] = pwdata[7:0];
          s_nxt.st      = rbd_pkg::ST_IDLE;
          s_nxt.pready  = 1'b0;
          s_nxt.pslverr = 1'b0;
          s_nxt.prdata  = 32'h00000000;
        end
      end
      default:
      begin
        s_nxt.st = rbd_pkg::ST_IDLE;
      end
    endcase
    // Rows are searched from 0 upward; with cumulative bounds at most one
    // window holds the address, so the order only matters for bad setups.
    if (acc_valid)
    begin
      s_nxt.done = 1'b1;
      s_nxt.miss = 1'b1;
      s_nxt.ma   = 14'h0000;
      for (int i = 0; i < 8; i++)
      begin
        if (row_hit[i] && !found)
        begin
          found             = 1'b1;
          s_nxt.miss        = 1'b0;
          s_nxt.strobe_n[i] = 1'b0;
          s_nxt.row         = 3'(i);
          s_nxt.typ         = s_r.regs[2*i+1][rbd_pkg::TYPE_LSB +: 2];
          s_nxt.map         = s_r.regs[2*i+1][rbd_pkg::MAP_LSB +: 2];
          s_nxt.ma          = ma_of_row[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r          <= '0;
      s_r.st       <= rbd_pkg::ST_IDLE;
      s_r.strobe_n <= 8'hFF;
      s_r.regs[0]  <= rbd_pkg::ROW0_LOW_RST;
      s_r.regs[1]  <= rbd_pkg::ROW0_HIGH_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pready             = s_r.pready;
  assign prdata             = s_r.prdata;
  assign pslverr            = s_r.pslverr;
  assign row_strobe_n       = s_r.strobe_n;
  assign memory_address_bus = s_r.ma;
  assign acc_done           = s_r.done;
  assign acc_miss           = s_r.miss;
  assign acc_row            = s_r.row;
  assign acc_type           = s_r.typ;
  assign acc_map            = s_r.map;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_setup_answer;
    psel && !penable && s_r.st == rbd_pkg::ST_IDLE |=> pready ##1 !pready;
  endproperty
  a_setup_answer: assert property (p_setup_answer)
    else $error("pready did not answer one cycle after setup");

  property p_write_lands;
    logic [3:0] ix;
    logic [7:0] dv;
    (pready && psel && penable && pwrite && reg_decode(paddr) >= 5'h10 && pstrb[0],
     ix = paddr[5:2], dv = pwdata[7:0]) |=> s_r.regs[ix] == dv;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("register write did not take effect");

  property p_read_back;
    psel && !penable && s_r.st == rbd_pkg::ST_IDLE && reg_decode(paddr) >= 5'h10
      |=> prdata[7:0] == s_r.regs[$past(paddr[5:2])] && prdata[31:8] == 24'h000000;
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data does not match the register");

  property p_one_strobe;
    $countones(~row_strobe_n) <= 1;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("more than one row strobe active");

  property p_access_time;
    acc_valid |=> acc_done ##1 (acc_done == $past(acc_valid));
  endproperty
  a_access_time: assert property (p_access_time)
    else $error("access answer not one cycle after request");

  property p_strobe_matches_row;
    acc_done && !acc_miss |-> row_strobe_n == ~(8'h01 << acc_row);
  endproperty
  a_strobe_matches_row: assert property (p_strobe_matches_row)
    else $error("strobe does not match the selected row");

  property p_miss_quiet;
    acc_done && acc_miss |-> row_strobe_n == 8'hFF && memory_address_bus == 14'h0000;
  endproperty
  a_miss_quiet: assert property (p_miss_quiet)
    else $error("strobe or bank bits driven on a miss");

  property p_inside_window;
    acc_valid ##1 (acc_done && !acc_miss) |->
      $past(acc_addr) < hi_bound[acc_row] && $past(acc_addr) >= lo_bound[acc_row];
  endproperty
  a_inside_window: assert property (p_inside_window)
    else $error("selected row does not hold the address");

  property p_disabled_row;
    acc_done && !acc_miss |->
      acc_type != rbd_pkg::TYPE_RSVD &&
      !(acc_map == rbd_pkg::MAP_OFF && acc_type != rbd_pkg::TYPE_SDRAM);
  endproperty
  a_disabled_row: assert property (p_disabled_row)
    else $error("disabled row was strobed");

  property p_bank_64m;
    acc_valid ##1 (acc_done && !acc_miss && acc_type == rbd_pkg::TYPE_SDRAM &&
                   acc_map == rbd_pkg::MAP_64M)
      |-> memory_address_bus == {1'b0, $past(acc_bank), 11'h000};
  endproperty
  a_bank_64m: assert property (p_bank_64m)
    else $error("bank select not on bits 12:11");

  property p_bank_x16;
    acc_valid ##1 (acc_done && !acc_miss && acc_type == rbd_pkg::TYPE_SDRAM &&
                   acc_map == rbd_pkg::MAP_X16)
      |-> memory_address_bus == {$past(acc_bank), 12'h000};
  endproperty
  a_bank_x16: assert property (p_bank_x16)
    else $error("bank select not on bits 13:12");

  property p_no_bank_else;
    acc_done && !acc_miss && (acc_type != rbd_pkg::TYPE_SDRAM || acc_map[1] == 1'b0)
      |-> memory_address_bus == 14'h0000;
  endproperty
  a_no_bank_else: assert property (p_no_bank_else)
    else $error("bank bits driven for a two-bank or non-SDRAM row");

  property p_refuse_unmapped;
    psel && !penable && s_r.st == rbd_pkg::ST_IDLE && reg_decode(paddr) < 5'h10
      |=> pready && pslverr && prdata == 32'h00000000;
  endproperty
  a_refuse_unmapped: assert property (p_refuse_unmapped)
    else $error("unmapped address was not refused");

  property p_no_refused_write;
    pready && psel && penable && pwrite && (reg_decode(paddr) < 5'h10 || !pstrb[0])
      |=> $stable(s_r.regs);
  endproperty
  a_no_refused_write: assert property (p_no_refused_write)
    else $error("refused write changed a register");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr raised outside the access phase");

  property p_rdata_quiet;
    !pready |-> prdata == 32'h00000000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data driven while pready is low");

  property p_strobe_needs_done;
    !acc_done |-> row_strobe_n == 8'hFF;
  endproperty
  a_strobe_needs_done: assert property (p_strobe_needs_done)
    else $error("row strobe active without an access answer");

  property p_done_needs_request;
    !acc_valid |=> !acc_done;
  endproperty
  a_done_needs_request: assert property (p_done_needs_request)
    else $error("access answer without a request");

  property p_bank_bits_hold;
    !acc_valid |=> $stable(memory_address_bus);
  endproperty
  a_bank_bits_hold: assert property (p_bank_bits_hold)
    else $error("bank bits changed without an access");

  property p_miss_means_no_hit;
    acc_valid |=> acc_miss == $past(row_hit == 8'h00);
  endproperty
  a_miss_means_no_hit: assert property (p_miss_means_no_hit)
    else $error("miss flag does not match the row windows");

endmodule

// >>> verification/rbd_mem_model.sv
`timescale 1ns/1ps
module rbd_mem_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Strobes and bank bits from the controller
  input  wire logic [7:0]  row_strobe_n,
  input  wire logic [13:0] memory_address_bus,
  // Observed activity
  output logic      [15:0] hit_count
);
  // Two strobes at once would let two module sides fight on the data bus,
  // so such a cycle is not counted; stray low address bits are refused too.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hit_count <= 16'h0000;
    end
    else if ($countones(~row_strobe_n) == 1 && memory_address_bus[10:0] == 11'h000)
    begin
      hit_count <= hit_count + 16'h0001;
    end
  end
endmodule

// >>> verification/rbd_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module rbd_top_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        acc_valid = 1'b0;
  logic [11:0] acc_addr = 12'h000;
  logic [1:0]  acc_bank = 2'h0;
  logic        pready, pslverr, acc_done, acc_miss;
  logic [31:0] prdata, rd;
  logic [7:0]  row_strobe_n;
  logic [13:0] memory_address_bus;
  logic [2:0]  acc_row;
  logic [1:0]  acc_type, acc_map;
  logic [15:0] hit_count;
  logic        err;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  cfg [16] = '{8'h08, 8'h40, 8'h08, 8'h00, 8'h10, 8'hD0, 8'h14, 8'h60,
                            8'h18, 8'h30, 8'h20, 8'hB0, 8'h28, 8'hF0, 8'h00, 8'h41};
  logic [35:0] at [9] = '{
    {12'h005, 2'h0, 1'b0, 3'd0, 4'h1, 14'h0000},
    {12'h00A, 2'h0, 1'b0, 3'd2, 4'h7, 14'h0000},
    {12'h00C, 2'h3, 1'b0, 3'd2, 4'h7, 14'h0000},
    {12'h012, 2'h0, 1'b1, 3'd0, 4'h0, 14'h0000},
    {12'h014, 2'h2, 1'b0, 3'd4, 4'hC, 14'h0000},
    {12'h01F, 2'h3, 1'b0, 3'd5, 4'hE, 14'h1800},
    {12'h027, 2'h2, 1'b0, 3'd6, 4'hF, 14'h2000},
    {12'h0FF, 2'h1, 1'b0, 3'd7, 4'h1, 14'h0000},
    {12'h100, 2'h0, 1'b1, 3'd0, 4'h0, 14'h0000}};

  always #2.5 core_clk = ~core_clk;

  rbd_top i_rbd_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_bank(acc_bank), .row_strobe_n(row_strobe_n), .memory_address_bus(memory_address_bus),
    .acc_done(acc_done), .acc_miss(acc_miss), .acc_row(acc_row), .acc_type(acc_type),
    .acc_map(acc_map));

  rbd_mem_model i_rbd_mem_model (.core_clk(core_clk), .rst(rst), .row_strobe_n(row_strobe_n),
    .memory_address_bus(memory_address_bus), .hit_count(hit_count));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // The access phase lasts until pready is seen at an edge, so wait states still work.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input logic x);
    apb(1'b0, idx, 32'h0000_0000, 4'h0);
    `CHK(rd, {24'h000000, e})
    `CHK(err, x)
  endtask

  task automatic acc(input logic [35:0] v);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_addr <= v[35:24];
    acc_bank <= v[23:22];
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
    `CHK(acc_done, 1'b1)
    `CHK(acc_miss, v[21])
    `CHK(row_strobe_n, v[21] ? 8'hFF : ~(8'h01 << v[20:18]))
    `CHK(memory_address_bus, v[13:0])
    if (!v[21])
    begin
      `CHK({acc_row, acc_type, acc_map}, v[20:14])
    end
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      rchk(8'h60 + i[7:0], i == 0 ? 8'h08 : (i == 1 ? 8'h40 : 8'h00), 1'b0);
    end
    rchk(8'h70, 8'h00, 1'b1);
    rchk(8'h5F, 8'h00, 1'b1);
    acc({12'h007, 2'h0, 1'b0, 3'd0, 4'h1, 14'h0000});
    acc({12'h008, 2'h0, 1'b1, 3'd0, 4'h0, 14'h0000});
    apb(1'b1, 8'h62, 32'hFFFF_FF5A, 4'h0);
    rchk(8'h62, 8'h00, 1'b0);
    apb(1'b1, 8'h62, 32'h0000_000C, 4'h1);
    acc({12'h00A, 2'h0, 1'b1, 3'd0, 4'h0, 14'h0000});
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, 8'h60 + i[7:0], {24'hFFFFFF, cfg[i]}, 4'h1);
    end
    for (int i = 0; i < 16; i++)
    begin
      rchk(8'h60 + i[7:0], cfg[i], 1'b0);
    end
    for (int j = 0; j < 9; j++)
    begin
      acc(at[j]);
    end
    @(posedge core_clk);
    #1;
    `CHK(row_strobe_n, 8'hFF)
    `CHK(hit_count, 16'd8)
    print_verdict();
  end
endmodule
